// [plc_pkg.sv]
// Package: field widths, element kinds, register map and reset values
package plc_pkg;

  // Field widths in bits
  localparam int unsigned PLC_FLAG_W  = 1;
  localparam int unsigned PLC_ADDR_W  = 48;
  localparam int unsigned PLC_NUM_W   = 6;
  localparam int unsigned PLC_CNT_W   = 8;
  localparam int unsigned PLC_LOC_W   = 14;
  localparam int unsigned PLC_CC_W    = 10;
  localparam int unsigned PLC_NC_W    = 14;
  localparam int unsigned PLC_CHAR_W  = 8;
  localparam int unsigned PLC_OWNER_W = 8;

  // Value limits
  localparam logic [5:0] PLC_PCT_MAX   = 6'h32;
  localparam logic [7:0] PLC_OWNER_RSV = 8'h00;

  // Bus and buffer widths
  localparam int unsigned PLC_AW   = 4;
  localparam int unsigned PLC_DW   = 64;
  localparam int unsigned PLC_BUFW = 49;
  localparam int unsigned PLC_BITC_W = 6;

  // Register offsets
  localparam logic [3:0] PLC_OFF_ENC_DATA = 4'h0;
  localparam logic [3:0] PLC_OFF_ENC_CTRL = 4'h1;
  localparam logic [3:0] PLC_OFF_DEC_CTRL = 4'h2;
  localparam logic [3:0] PLC_OFF_DEC_DATA = 4'h3;
  localparam logic [3:0] PLC_OFF_STATUS   = 4'h4;

  // Control field positions
  localparam int unsigned PLC_CTL_KIND_LSB = 0;
  localparam int unsigned PLC_CTL_HEAD_BIT = 4;
  localparam int unsigned PLC_CTL_AIR_BIT  = 5;
  localparam int unsigned PLC_CTL_CNT_LSB  = 8;

  // Status bit positions
  localparam int unsigned PLC_ST_ENC_BUSY  = 0;
  localparam int unsigned PLC_ST_DEC_BUSY  = 1;
  localparam int unsigned PLC_ST_DEC_VALID = 2;
  localparam int unsigned PLC_ST_ERR_LSB   = 4;
  localparam int unsigned PLC_ERR_N        = 5;
  localparam int unsigned PLC_E_PCT_RX     = 0;
  localparam int unsigned PLC_E_OWNER_RX   = 1;
  localparam int unsigned PLC_E_RESERVED   = 2;
  localparam int unsigned PLC_E_AIR        = 3;
  localparam int unsigned PLC_E_BUSY       = 4;

  // Reset values
  localparam logic [47:0] PLC_RST_DATA = 48'h0000_0000_0000;
  localparam logic [4:0]  PLC_RST_ERR  = 5'h00;

  typedef enum logic [3:0] {
    PLC_K_POLL_REQ = 4'h0,
    PLC_K_POLL_RSP = 4'h1,
    PLC_K_ADDR     = 4'h2,
    PLC_K_NUM      = 4'h3,
    PLC_K_PCT      = 4'h4,
    PLC_K_LOC      = 4'h5,
    PLC_K_CC       = 4'h6,
    PLC_K_NC       = 4'h7,
    PLC_K_SERIAL   = 4'h8,
    PLC_K_PROP     = 4'h9
  } plc_kind_t;

  // Width of one item of an element kind
  function automatic logic [5:0] plc_item_w(input logic [3:0] k);
    case (k)
      PLC_K_ADDR:   plc_item_w = 6'(PLC_ADDR_W);
      PLC_K_NUM,
      PLC_K_PCT:    plc_item_w = 6'(PLC_NUM_W);
      PLC_K_LOC:    plc_item_w = 6'(PLC_LOC_W);
      PLC_K_CC:     plc_item_w = 6'(PLC_CC_W);
      PLC_K_NC:     plc_item_w = 6'(PLC_NC_W);
      PLC_K_SERIAL,
      PLC_K_PROP:   plc_item_w = 6'(PLC_CHAR_W);
      default:      plc_item_w = 6'(PLC_FLAG_W);
    endcase
  endfunction

  // Element kinds whose item count arrives in an 8-bit head
  function automatic logic plc_is_list(input logic [3:0] k);
    plc_is_list = (k == PLC_K_LOC) || (k == PLC_K_CC) || (k == PLC_K_NC);
  endfunction

endpackage

// [plc_buf2.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module plc_buf2 #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_srst,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign push        = i_in_valid && (cnt_r != 2'h2);
  assign pop         = i_out_ready && (cnt_r != 2'h0);
  assign o_in_ready  = (cnt_r != 2'h2);
  assign o_out_valid = (cnt_r != 2'h0);
  assign o_out_data  = mem_r[rp_r];

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// [plc_codec.sv]
// Poll, list, serial and owner field encoder and decoder
//
// Notes on behaviour
// RULE1: Poll request is one bit; 1 asks the station for a poll answer.
// RULE2: Poll response is one bit; 1 means the station responds.
// RULE3: Poll response addresses are a run of 48-bit subscriber identities.
// RULE4: Responding member count is a 6-bit unsigned value, 0 to 63.
// RULE5: Percentage is 6 bits in 2 % steps; 51 to 63 never generated.
// RULE6: Location-area list: 8-bit count, then that many 14-bit entries.
// RULE7: Country-code list: 8-bit count, then that many 10-bit entries.
// RULE8: Network-code list: 8-bit count, then that many 14-bit entries.
// RULE9: Serial number is a string of 8-bit characters.
// RULE10: Proprietary element is optional; streams without it are accepted.
// RULE11: Proprietary element starts with an 8-bit owner code.
// RULE12: Content after the owner is passed through unmodified.
// RULE13: Owner code 0 is reserved and never sent; 1 to 255 are owners.
// RULE14: Proprietary content is never sent towards the air interface.
// RULE15: Fields go most significant bit first; reserved values flag errors.
`timescale 1ns/1ps
module plc_codec
  import plc_pkg::*;
(
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_srst,
  // Register port
  input  wire logic [PLC_AW-1:0] i_addr,
  input  wire logic [PLC_DW-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [PLC_DW-1:0]      o_rdata,
  // Transmit bit stream
  output logic                   o_tx_bit,
  output logic                   o_tx_valid,
  output logic                   o_tx_air,
  input  wire logic              i_tx_ready,
  // Receive bit stream
  input  wire logic              i_rx_bit,
  input  wire logic              i_rx_valid,
  output logic                   o_rx_ready
);

  //////////////////////////////////////////////////////////////////////////
  // Register decode

  logic wr_enc_data;
  logic wr_enc_ctrl;
  logic wr_dec_ctrl;
  logic wr_status;
  logic rd_dec_data;

  assign wr_enc_data = i_wr && (i_addr == PLC_OFF_ENC_DATA);
  assign wr_enc_ctrl = i_wr && (i_addr == PLC_OFF_ENC_CTRL);
  assign wr_dec_ctrl = i_wr && (i_addr == PLC_OFF_DEC_CTRL);
  assign wr_status   = i_wr && (i_addr == PLC_OFF_STATUS);
  assign rd_dec_data = i_rd && (i_addr == PLC_OFF_DEC_DATA);

  //////////////////////////////////////////////////////////////////////////
  // Encoder

  typedef enum logic [1:0] {
    PLC_E_IDLE = 2'b00,
    PLC_E_SEND = 2'b01
  } plc_enc_st_t;

  plc_enc_st_t enc_st_r;
  logic [47:0] enc_data_r;
  logic [47:0] enc_sh_r;
  logic [5:0]  enc_left_r;
  logic        tx_valid_r;
  logic        tx_bit_r;
  logic        tx_air_r;

  logic [3:0]  ec_kind;
  logic        ec_head;
  logic        ec_air;
  logic [5:0]  ec_w;
  logic        ec_bad_rsv;
  logic        ec_bad_air;
  logic        ec_busy;
  logic        ec_go;
  logic [47:0] ec_aligned;
  logic        tx_step;

  assign ec_kind = i_wdata[PLC_CTL_KIND_LSB +: 4];
  assign ec_head = i_wdata[PLC_CTL_HEAD_BIT];
  assign ec_air  = i_wdata[PLC_CTL_AIR_BIT];
  assign ec_w    = ec_head ? 6'(PLC_CNT_W) : plc_item_w(ec_kind);

  // Reserved percentages and owner 0 are refused, not sent
  assign ec_bad_rsv =
    (!ec_head && (ec_kind == PLC_K_PCT) &&
     (enc_data_r[5:0] > PLC_PCT_MAX)) ||                // RULE5
    (ec_head && (ec_kind == PLC_K_PROP) &&
     (enc_data_r[7:0] == PLC_OWNER_RSV));               // RULE13
  assign ec_bad_air = ec_air && (ec_kind == PLC_K_PROP); // RULE14
  assign ec_busy    = (enc_st_r != PLC_E_IDLE);
  assign ec_go      = wr_enc_ctrl && !ec_busy && !ec_bad_rsv && !ec_bad_air;

  // Left-align so the top bit leaves first
  assign ec_aligned = enc_data_r << (7'd48 - {1'b0, ec_w}); // RULE15
  assign tx_step    = tx_valid_r && i_tx_ready;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      enc_data_r <= PLC_RST_DATA;
    end else if (wr_enc_data) begin
      enc_data_r <= i_wdata[47:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      enc_st_r   <= PLC_E_IDLE;
      enc_sh_r   <= PLC_RST_DATA;
      enc_left_r <= 6'h00;
      tx_valid_r <= 1'b0;
      tx_bit_r   <= 1'b0;
      tx_air_r   <= 1'b0;
    end else begin
      case (enc_st_r)
        PLC_E_IDLE: begin
          if (ec_go) begin
            // Single flags, counts, entries, characters, owner
            enc_st_r   <= PLC_E_SEND;  // RULE1 RULE2 RULE3 RULE4
            enc_sh_r   <= ec_aligned << 1;      // RULE6 RULE7 RULE8
            enc_left_r <= ec_w;                 // RULE9 RULE11
            tx_bit_r   <= ec_aligned[47];
            tx_valid_r <= 1'b1;
            tx_air_r   <= ec_air;
          end
        end
        PLC_E_SEND: begin
          if (tx_step) begin
            if (enc_left_r == 6'h01) begin
              enc_st_r   <= PLC_E_IDLE;
              tx_valid_r <= 1'b0;
            end else begin
              tx_bit_r <= enc_sh_r[47];
              enc_sh_r <= enc_sh_r << 1;
            end
            enc_left_r <= enc_left_r - 6'h01;
          end
        end
        default: begin
          enc_st_r   <= PLC_E_IDLE;
          tx_valid_r <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Decoder

  typedef enum logic [1:0] {
    PLC_D_IDLE = 2'b00,
    PLC_D_HEAD = 2'b01,
    PLC_D_BODY = 2'b11,
    PLC_D_PUSH = 2'b10
  } plc_dec_st_t;

  plc_dec_st_t dec_st_r;
  plc_dec_st_t dec_st_nxt;
  logic [3:0]  dec_kind_r;
  logic [7:0]  dec_sw_cnt_r;
  logic [7:0]  dec_left_r;
  logic [47:0] dec_sh_r;
  logic [5:0]  dec_bits_r;
  logic        dec_is_head_r;
  logic        rx_ready_r;

  logic [3:0]  dc_kind;
  logic [7:0]  dc_cnt;
  logic        dc_has_head;
  logic        rx_take;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic [PLC_BUFW-1:0] buf_out_data;
  logic        push_ok;
  logic [7:0]  head_items;
  logic        bad_pct;
  logic        bad_owner;

  assign dc_kind = i_wdata[PLC_CTL_KIND_LSB +: 4];
  assign dc_cnt  = i_wdata[PLC_CTL_CNT_LSB +: 8];
  // Lists carry their own count; proprietary carries the owner first
  assign dc_has_head = plc_is_list(dc_kind) ||
                       (dc_kind == PLC_K_PROP);         // RULE11
  assign rx_take = rx_ready_r && i_rx_valid;
  assign push_ok = (dec_st_r == PLC_D_PUSH) && buf_in_ready;

  // Item count after the head: from the stream for lists, else software
  assign head_items = plc_is_list(dec_kind_r) ?
                      dec_sh_r[7:0] :                   // RULE6 RULE7 RULE8
                      dec_sw_cnt_r;                     // RULE12

  assign bad_pct   = push_ok && !dec_is_head_r &&
                     (dec_kind_r == PLC_K_PCT) &&
                     (dec_sh_r[5:0] > PLC_PCT_MAX);     // RULE5 RULE15
  assign bad_owner = push_ok && dec_is_head_r &&
                     (dec_kind_r == PLC_K_PROP) &&
                     (dec_sh_r[7:0] == PLC_OWNER_RSV);  // RULE13 RULE15

  always_comb begin
    dec_st_nxt = dec_st_r;
    case (dec_st_r)
      PLC_D_IDLE: begin
        if (wr_dec_ctrl) begin
          dec_st_nxt = dc_has_head ? PLC_D_HEAD : PLC_D_BODY;
        end
      end
      PLC_D_HEAD,
      PLC_D_BODY: begin
        if (rx_take && (dec_bits_r == 6'h01)) begin
          dec_st_nxt = PLC_D_PUSH;
        end
      end
      PLC_D_PUSH: begin
        if (buf_in_ready) begin
          if (dec_is_head_r) begin
            // An empty list or bare owner ends the element
            dec_st_nxt = (head_items == 8'h00) ?
                         PLC_D_IDLE : PLC_D_BODY;       // RULE10
          end else begin
            dec_st_nxt = (dec_left_r == 8'h01) ?
                         PLC_D_IDLE : PLC_D_BODY;
          end
        end
      end
      default: dec_st_nxt = PLC_D_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      dec_st_r <= PLC_D_IDLE;
    end else begin
      dec_st_r <= dec_st_nxt;
    end
  end

  // Ready registered so the receiver sees a flop; drops while pushing
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rx_ready_r <= 1'b0;
    end else begin
      rx_ready_r <= (dec_st_nxt == PLC_D_HEAD) ||
                    (dec_st_nxt == PLC_D_BODY);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      dec_kind_r    <= 4'h0;
      dec_sw_cnt_r  <= 8'h00;
      dec_left_r    <= 8'h00;
      dec_sh_r      <= PLC_RST_DATA;
      dec_bits_r    <= 6'h00;
      dec_is_head_r <= 1'b0;
    end else begin
      case (dec_st_r)
        PLC_D_IDLE: begin
          if (wr_dec_ctrl) begin
            dec_kind_r    <= dc_kind;
            dec_sw_cnt_r  <= dc_cnt;
            // Single-value kinds always decode one item
            dec_left_r    <= (plc_item_w(dc_kind) <= 6'(PLC_NUM_W)) ?
                             8'h01 : dc_cnt;
            dec_sh_r      <= PLC_RST_DATA;
            dec_is_head_r <= dc_has_head;
            dec_bits_r    <= dc_has_head ? 6'(PLC_CNT_W) :
                             plc_item_w(dc_kind);
          end
        end
        PLC_D_HEAD,
        PLC_D_BODY: begin
          if (rx_take) begin
            dec_sh_r   <= {dec_sh_r[46:0], i_rx_bit};    // RULE15
            dec_bits_r <= dec_bits_r - 6'h01;
          end
        end
        PLC_D_PUSH: begin
          if (buf_in_ready) begin
            dec_sh_r      <= PLC_RST_DATA;
            dec_is_head_r <= 1'b0;
            dec_bits_r    <= plc_item_w(dec_kind_r);
            if (dec_is_head_r) begin
              dec_left_r <= head_items;
            end else begin
              dec_left_r <= dec_left_r - 8'h01;
            end
          end
        end
        default: begin
          dec_is_head_r <= 1'b0;
        end
      endcase
    end
  end

  // Decoded words wait here until software reads them
  plc_buf2 #(
    .W (PLC_BUFW)
  ) u_buf (
    .i_mclk      (i_mclk),
    .i_srst      (i_srst),
    .i_in_valid  (dec_st_r == PLC_D_PUSH),
    .i_in_data   ({dec_is_head_r, dec_sh_r}),
    .o_in_ready  (buf_in_ready),
    .o_out_valid (buf_out_valid),
    .o_out_data  (buf_out_data),
    .i_out_ready (rd_dec_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // Sticky error flags, write one to clear; a new event beats the clear

  logic [PLC_ERR_N-1:0] err_r;
  logic [PLC_ERR_N-1:0] err_set;
  logic [PLC_ERR_N-1:0] err_clr;

  always_comb begin
    err_set                 = '0;
    err_set[PLC_E_PCT_RX]   = bad_pct;
    err_set[PLC_E_OWNER_RX] = bad_owner;
    err_set[PLC_E_RESERVED] = wr_enc_ctrl && !ec_busy && ec_bad_rsv;
    err_set[PLC_E_AIR]      = wr_enc_ctrl && !ec_busy && ec_bad_air;
    err_set[PLC_E_BUSY]     = wr_enc_ctrl && ec_busy;
  end

  assign err_clr = wr_status ?
                   i_wdata[PLC_ST_ERR_LSB +: PLC_ERR_N] : '0;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      err_r <= PLC_RST_ERR;
    end else begin
      err_r <= (err_r & ~err_clr) | err_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, valid only in the cycle after the strobe

  logic [PLC_DW-1:0] rdata_r;
  logic [PLC_DW-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (i_addr)
      PLC_OFF_ENC_DATA: rd_mux[47:0] = enc_data_r;
      PLC_OFF_DEC_DATA: begin
        if (buf_out_valid) begin
          // Bit 48 marks a head word: count or owner
          rd_mux[PLC_BUFW-1:0] = buf_out_data;
        end
      end
      PLC_OFF_DEC_CTRL: begin
        rd_mux[PLC_CTL_KIND_LSB +: 4] = dec_kind_r;
        rd_mux[PLC_CTL_CNT_LSB +: 8]  = dec_sw_cnt_r;
      end
      PLC_OFF_STATUS: begin
        rd_mux[PLC_ST_ENC_BUSY]  = ec_busy;
        rd_mux[PLC_ST_DEC_BUSY]  = (dec_st_r != PLC_D_IDLE);
        rd_mux[PLC_ST_DEC_VALID] = buf_out_valid;
        rd_mux[PLC_ST_ERR_LSB +: PLC_ERR_N] = err_r;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_r <= '0;
    end else if (i_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= '0;
    end
  end

  assign o_rdata    = rdata_r;
  assign o_tx_bit   = tx_bit_r;
  assign o_tx_valid = tx_valid_r;
  assign o_tx_air   = tx_air_r;
  assign o_rx_ready = rx_ready_r;

endmodule

// [plc_codec_monitor.sv]
// Port checker for the field codec
`timescale 1ns/1ps
module plc_codec_monitor
  import plc_pkg::*;
(
  input wire logic              i_mclk,
  input wire logic              i_srst,
  input wire logic [PLC_AW-1:0] i_addr,
  input wire logic [PLC_DW-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [PLC_DW-1:0] o_rdata,
  input wire logic              o_tx_bit,
  input wire logic              o_tx_valid,
  input wire logic              o_tx_air,
  input wire logic              i_tx_ready,
  input wire logic              i_rx_bit,
  input wire logic              i_rx_valid,
  input wire logic              o_rx_ready
);
  logic [47:0] data_r;
  logic [47:0] sh_r;
  logic [5:0]  cnt_r;
  logic [5:0]  w_r;
  logic [5:0]  w_nxt;
  logic [5:0]  idx;
  logic [3:0]  dk_r;
  logic        ctl;
  logic        pct_bad;
  logic        own_bad;
  logic        air_bad;
  logic        st_ok;
  ////////////////////////////////////////
  assign ctl = i_wr && i_addr == PLC_OFF_ENC_CTRL && !o_tx_valid;
  assign pct_bad = i_wdata[4:0] == 5'h04 && data_r[5:0] > 6'h32;
  assign own_bad = i_wdata[4:0] == 5'h19 && data_r[7:0] == 8'h00;
  assign air_bad = i_wdata[3:0] == 4'h9 && i_wdata[5];
  assign st_ok = ctl && i_wdata[3:0] <= 4'h9 && !pct_bad && !own_bad
                 && !air_bad;
  // Bit still owed, counted down from the top
  assign idx = w_r - 6'h01 - cnt_r;
  always_comb begin
    case (i_wdata[3:0])
      4'h2: w_nxt = 6'h30;
      4'h3, 4'h4: w_nxt = 6'h06;
      4'h5, 4'h7: w_nxt = 6'h0E;
      4'h6: w_nxt = 6'h0A;
      4'h8, 4'h9: w_nxt = 6'h08;
      default: w_nxt = 6'h01;
    endcase
    if (i_wdata[4]) w_nxt = 6'h08;
  end
  always_ff @(posedge i_mclk) begin
    if (i_srst) data_r <= '0;
    else if (i_wr && i_addr == PLC_OFF_ENC_DATA) data_r <= i_wdata[47:0];
  end
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sh_r <= '0;
      w_r <= 6'h01;
      cnt_r <= '0;
    end else if (st_ok) begin
      sh_r <= data_r;
      w_r <= w_nxt;
      cnt_r <= '0;
    end else if (o_tx_valid && i_tx_ready) cnt_r <= cnt_r + 6'h01;
  end
  always_ff @(posedge i_mclk) begin
    if (i_srst) dk_r <= 4'hF;
    else if (i_wr && i_addr == PLC_OFF_DEC_CTRL) dk_r <= i_wdata[3:0];
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  sequence s_bit_wait;
    o_tx_valid && !i_tx_ready;
  endsequence
  sequence s_one_taken;
    o_rx_ready && i_rx_valid && dk_r[3:1] == 3'h0;
  endsequence
  a_reset_quiet: assert property ($past(i_srst) |->
    !o_tx_valid && !o_rx_ready && o_rdata == '0)
    else $error("outputs busy after reset");
  a_rdata_zero: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside its cycle");
  a_tx_start: assert property (st_ok |=> o_tx_valid)
    else $error("encoder did not start");
  a_tx_order: assert property (o_tx_valid |-> o_tx_bit == sh_r[idx])
    else $error("serial bit out of order");
  a_tx_hold: assert property (s_bit_wait |=> o_tx_valid && $stable(o_tx_bit))
    else $error("bit changed before taken");
  a_tx_width: assert property ($fell(o_tx_valid) |-> cnt_r == w_r)
    else $error("field width wrong");
  a_pct_refuse: assert property (ctl && pct_bad |=> !o_tx_valid [*2])
    else $error("reserved percentage sent");
  a_owner_refuse: assert property (ctl && own_bad |=> !o_tx_valid [*2])
    else $error("reserved owner sent");
  a_air_refuse: assert property (ctl && air_bad |=> !o_tx_valid [*2])
    else $error("proprietary sent to air");
  a_rx_single: assert property (s_one_taken |=> !o_rx_ready [*2])
    else $error("flag field took extra bits");
endmodule

// [plc_te_model.sv]
// Terminal equipment model: stalling bit sink and bit source
`timescale 1ns/1ps
module plc_te_model (
  // Clock and control
  input  wire logic i_mclk,
  input  wire logic i_srst,
  input  wire logic i_slow,
  // Bits from the codec
  input  wire logic i_tx_bit,
  input  wire logic i_tx_valid,
  output logic      o_tx_ready,
  // Bits to the codec
  output logic      o_rx_bit,
  output logic      o_rx_valid,
  input  wire logic i_rx_ready
);
  bit          q[$];
  logic [63:0] got = '0;
  int          n_got = 0;
  ////////////////////////////////////////
  task automatic send(input logic [63:0] v, input int w);
    for (int i = w - 1; i >= 0; i--) q.push_back(v[i]);
  endtask
  initial begin
    o_tx_ready = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_bit = 1'b0;
  end
  always @(posedge i_mclk) begin
    if (i_tx_valid && o_tx_ready) begin
      got = {got[62:0], i_tx_bit};
      n_got++;
    end
    o_tx_ready <= i_slow ? 1'($urandom_range(1)) : 1'b1;
    if (o_rx_valid && i_rx_ready) void'(q.pop_front());
    if (q.size() > 0 && !i_srst) begin
      o_rx_valid <= 1'b1;
      o_rx_bit <= q[0];
    end else begin
      // Idle line never repeats the last bit
      o_rx_valid <= 1'b0;
      o_rx_bit <= ~o_rx_bit;
    end
  end
endmodule

// [plc_codec_tb_top.sv]
// Testbench for the field codec
`timescale 1ns/1ps
module plc_codec_tb_top
  import plc_pkg::*;
;
  logic              i_mclk = 1'b0;
  logic              i_srst = 1'b1;
  logic [PLC_AW-1:0] i_addr = '0;
  logic [PLC_DW-1:0] i_wdata = '0;
  logic [PLC_DW-1:0] o_rdata;
  logic [PLC_DW-1:0] rv;
  logic              i_wr = 1'b0;
  logic              i_rd = 1'b0;
  logic              slow = 1'b0;
  logic              o_tx_bit, o_tx_valid, o_tx_air, i_tx_ready;
  logic              i_rx_bit, i_rx_valid, o_rx_ready;
  int                n_fail = 0;
  int                checked = 0;
  logic [7:0]        rdat [4] = '{8'h33, 8'h3F, 8'h00, 8'h5A};
  logic [5:0]        rctl [4] = '{6'h04, 6'h04, 6'h19, 6'h29};
  int                rbit [4] = '{6, 6, 6, 7};
  always #5 i_mclk = ~i_mclk;
  plc_codec u_plc_codec (.*);
  plc_te_model u_plc_te_model (
    .i_mclk     (i_mclk),
    .i_srst     (i_srst),
    .i_slow     (slow),
    .i_tx_bit   (o_tx_bit),
    .i_tx_valid (o_tx_valid),
    .o_tx_ready (i_tx_ready),
    .o_rx_bit   (i_rx_bit),
    .o_rx_valid (i_rx_valid),
    .i_rx_ready (o_rx_ready)
  );
  ////////////////////////////////////////
  function automatic int kw(input logic [3:0] k);
    case (k)
      4'h2: return 48;
      4'h3, 4'h4: return 6;
      4'h5, 4'h7: return 14;
      4'h6: return 10;
      4'h8, 4'h9: return 8;
      default: return 1;
    endcase
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [63:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic wait_st(input int b, input logic val);
    int n;
    n = 0;
    do begin
      rd(PLC_OFF_STATUS, rv);
      n++;
    end while (rv[b] !== val && n < 300);
    chk(64'(rv[b]), 64'(val));
  endtask
  task automatic enc(input logic [3:0] k, input logic h, input logic [47:0] v);
    u_plc_te_model.n_got = 0;
    u_plc_te_model.got = '0;
    wr(PLC_OFF_ENC_DATA, 64'(v));
    // Network-code fields are marked for the air path
    wr(PLC_OFF_ENC_CTRL, 64'({k == 4'h7, h, k}));
    wait_st(PLC_ST_ENC_BUSY, 1'b0);
    chk(64'(o_tx_air), 64'(k == 4'h7));
    chk(64'(u_plc_te_model.n_got), 64'(h ? 8 : kw(k)));
    chk(u_plc_te_model.got, 64'(v));
  endtask
  task automatic dec_rd(input logic h, input logic [47:0] v);
    wait_st(PLC_ST_DEC_VALID, 1'b1);
    rd(PLC_OFF_DEC_DATA, rv);
    chk(rv, {15'h0000, h, v});
  endtask
  task automatic complete_run();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge i_mclk);
    n_fail++;
    complete_run();
  end
  initial begin
    logic [47:0] v;
    int          w;
    void'($urandom(32'h2104));
    repeat (10) @(posedge i_mclk);
    i_srst <= 1'b0;
    rd(PLC_OFF_STATUS, rv);
    chk(rv, 64'h0);
    rd(4'hF, rv);
    chk(rv, 64'h0);
    wr(PLC_OFF_ENC_DATA, 64'hFFFF_A5C3_0F96_7E81);
    rd(PLC_OFF_ENC_DATA, rv);
    chk(rv, 64'h0000_A5C3_0F96_7E81);
    // Every kind once, odd kinds against a stalling sink
    for (int k = 0; k < 10; k++) begin
      w = kw(4'(k));
      v = 48'({$urandom, $urandom}) & ((48'h1 << w) - 48'h1);
      if (k == 4) v = 48'h32;
      slow <= k[0];
      enc(4'(k), 1'b0, v);
    end
    for (int k = 5; k < 10; k++) begin
      if (k != 8) enc(4'(k), 1'b1, 48'($urandom_range(255, 1)));
    end
    for (int i = 0; i < 4; i++) begin
      wr(PLC_OFF_ENC_DATA, 64'(rdat[i]));
      wr(PLC_OFF_ENC_CTRL, 64'(rctl[i]));
      rd(PLC_OFF_STATUS, rv);
      chk(rv, 64'h1 << rbit[i]);
      wr(PLC_OFF_STATUS, 64'h1F0);
      rd(PLC_OFF_STATUS, rv);
      chk(rv, 64'h0);
    end
    // Second start while a 48-bit field is still leaving
    wr(PLC_OFF_ENC_CTRL, 64'h2);
    wr(PLC_OFF_ENC_CTRL, 64'h2);
    rd(PLC_OFF_STATUS, rv);
    chk(rv, 64'h101);
    wait_st(PLC_ST_ENC_BUSY, 1'b0);
    wr(PLC_OFF_STATUS, 64'h1F0);
    for (int k = 0; k < 5; k++) begin
      w = kw(4'(k));
      v = 48'({$urandom, $urandom}) & ((48'h1 << w) - 48'h1);
      if (k == 4) v = 48'h37;
      u_plc_te_model.send(64'(v), w);
      wr(PLC_OFF_DEC_CTRL, 64'h100 | 64'(k));
      dec_rd(1'b0, v);
    end
    rd(PLC_OFF_STATUS, rv);
    chk(rv, 64'h10);
    wr(PLC_OFF_STATUS, 64'h1F0);
    // Leave the buffer full so the decoder has to stall
    u_plc_te_model.send(64'h03, 8);
    for (int i = 0; i < 3; i++) u_plc_te_model.send(64'(10'h2A5 + i), 10);
    wr(PLC_OFF_DEC_CTRL, 64'h6);
    repeat (100) @(posedge i_mclk);
    chk(64'(u_plc_te_model.q.size()), 64'hA);
    rd(PLC_OFF_STATUS, rv);
    chk(rv, 64'h6);
    rd(PLC_OFF_DEC_CTRL, rv);
    chk(rv, 64'h6);
    dec_rd(1'b1, 48'h3);
    for (int i = 0; i < 3; i++) dec_rd(1'b0, 48'(10'h2A5 + i));
    u_plc_te_model.send(64'h0, 8);
    u_plc_te_model.send(64'hC33C, 16);
    wr(PLC_OFF_DEC_CTRL, 64'h209);
    dec_rd(1'b1, 48'h0);
    dec_rd(1'b0, 48'hC3);
    dec_rd(1'b0, 48'h3C);
    rd(PLC_OFF_STATUS, rv);
    chk(rv, 64'h20);
    rd(PLC_OFF_DEC_DATA, rv);
    chk(rv, 64'h0);
    complete_run();
  end
endmodule
bind plc_codec plc_codec_monitor u_plc_codec_monitor (.*);
